// file: verilog/osrg_top.sv
`include "osrg_regs.svh"

module osrg_top
    import osrg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Operation source
    input wire logic op_cond_in,
    // Command and query port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire osrg_sel_t sel,
    input wire osrg_word_t wr_data,
    output osrg_word_t rd_data,
    output logic rd_valid,
    // Summary
    output logic summary
);

    function automatic osrg_word_t used_only(input osrg_word_t v);
        used_only = v & `OSRG_USED_MASK;
    endfunction : used_only

    osrg_word_t cond_q, cond_d;
    osrg_word_t enab_q, enab_d;
    osrg_word_t evnt_q, evnt_d;
    osrg_word_t rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic summary_q, summary_d;
    logic prev_q, prev_d;
    logic rise;

    // Next-state logic
    always_comb
    begin
        prev_d = op_cond_in;
        rise = op_cond_in & ~prev_q;
        cond_d = `OSRG_COND_VAL;
        enab_d = enab_q;
        evnt_d = evnt_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        if (wr_en && sel == `OSRG_SEL_ENAB)
        begin
            enab_d = used_only(wr_data);
        end
        if (rd_en)
        begin
            rd_valid_d = 1'b1;
            unique case (sel)
                `OSRG_SEL_COND: rd_data_d = cond_q;
                `OSRG_SEL_ENAB: rd_data_d = enab_q;
                `OSRG_SEL_EVNT:
                begin
                    rd_data_d = evnt_q;
                    evnt_d = `OSRG_EVNT_RST;
                end
                default: rd_data_d = 16'h0000;
            endcase
        end
        // Set wins over read-clear
        if (rise)
        begin
            evnt_d[`OSRG_USED_BIT] = 1'b1;
        end
        summary_d = |(evnt_d & enab_d);
    end

    // Registers
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cond_q <= `OSRG_COND_VAL;
            enab_q <= `OSRG_ENAB_RST;
            evnt_q <= `OSRG_EVNT_RST;
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            summary_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            cond_q <= cond_d;
            enab_q <= enab_d;
            evnt_q <= evnt_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            summary_q <= summary_d;
            prev_q <= prev_d;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign summary = summary_q;

    // Checks
    sequence s_rise;
        !op_cond_in ##1 op_cond_in;
    endsequence
    sequence s_fall;
        op_cond_in ##1 !op_cond_in;
    endsequence
    sequence s_evnt_read;
        rd_en && sel == `OSRG_SEL_EVNT && !rise;
    endsequence
    sequence s_enab_write;
        wr_en && sel == `OSRG_SEL_ENAB;
    endsequence

    a_cond_reads_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en && sel == `OSRG_SEL_COND |=> rd_valid && rd_data == 16'h0000)
        else $error("condition query not zero");
    a_cond_no_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en && sel == `OSRG_SEL_COND && !wr_en
        |=> (evnt_q == $past(evnt_q) || $past(rise)) && cond_q == 16'h0000)
        else $error("condition query disturbed events");
    a_enab_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en && sel == `OSRG_SEL_ENAB && !wr_en |=> rd_data == enab_q && enab_q == $past(enab_q))
        else $error("enable query wrong");
    a_enab_used_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
        (enab_q & ~16'h0100) == 16'h0000 && (evnt_q & ~16'h0100) == 16'h0000)
        else $error("unused bit set");
    a_event_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_rise |=> evnt_q[8])
        else $error("rise not latched");
    a_event_no_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
        !evnt_q[8] && !rise |=> !evnt_q[8])
        else $error("event set without rise");
    a_event_rdclr: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en && sel == `OSRG_SEL_EVNT && !rise |=> rd_data == $past(evnt_q) && evnt_q == 16'h0000)
        else $error("event query not cleared");
    a_summary_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 summary == |(evnt_q & enab_q))
        else $error("summary mismatch");
    a_mask_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
        enab_q == 16'h0000 |-> !summary)
        else $error("masked event reported");

    // Reset and read port
    a_reset_clear: assert property (@(posedge clk_sys)
        !rstn |=> rd_data == 16'h0000 && !rd_valid && !summary
            && enab_q == `OSRG_ENAB_RST && evnt_q == `OSRG_EVNT_RST)
        else $error("state not cleared by reset");
    a_valid_on_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en |=> rd_valid)
        else $error("query not answered");
    a_valid_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
        !rd_en |=> !rd_valid)
        else $error("answer without query");
    a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
        !rd_en |=> $stable(rd_data))
        else $error("answer changed without query");
    a_rdata_used_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
        (rd_data & ~`OSRG_USED_MASK) == 16'h0000)
        else $error("answer shows unused bit");
    a_spare_sel_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en && sel == 2'h3 |=> rd_data == 16'h0000)
        else $error("spare select not zero");
    a_enab_answer: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en && sel == `OSRG_SEL_ENAB |=> rd_data == $past(enab_q))
        else $error("enable query answer wrong");

    // Enable mask
    a_mask_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_enab_write |=> enab_q == ($past(wr_data) & `OSRG_USED_MASK))
        else $error("mask not stored");
    a_mask_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(wr_en && sel == `OSRG_SEL_ENAB) |=> $stable(enab_q))
        else $error("mask changed without write");
    a_cond_keeps_mask: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_en && sel == `OSRG_SEL_COND && !wr_en |=> $stable(enab_q))
        else $error("condition query disturbed mask");
    a_mask_zero_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_enab_write ##0 !wr_data[`OSRG_USED_BIT] |=> !summary)
        else $error("summary despite cleared mask");

    // Event latch
    a_event_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
        evnt_q[`OSRG_USED_BIT] && !(rd_en && sel == `OSRG_SEL_EVNT) |=> evnt_q[`OSRG_USED_BIT])
        else $error("event lost without query");
    a_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
        rise && rd_en && sel == `OSRG_SEL_EVNT |=> evnt_q[`OSRG_USED_BIT] && rd_valid)
        else $error("read clear beat a new event");
    a_fall_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_fall ##0 !evnt_q[`OSRG_USED_BIT] |=> !evnt_q[`OSRG_USED_BIT])
        else $error("falling condition latched");
    a_rdclr_twice: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_evnt_read ##1 s_evnt_read |=> rd_data == 16'h0000)
        else $error("second event query not zero");

    // Summary output and condition register
    a_summary_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_rise ##0 (enab_q[`OSRG_USED_BIT] && !(wr_en && sel == `OSRG_SEL_ENAB)) |=> summary)
        else $error("enabled rise not summarised");
    a_summary_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_evnt_read |=> !summary)
        else $error("summary stays after event query");
    a_summary_source: assert property (@(posedge clk_sys) disable iff (!rstn)
        summary |-> evnt_q[`OSRG_USED_BIT] && enab_q[`OSRG_USED_BIT])
        else $error("summary without enabled event");
    a_cond_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        cond_q == `OSRG_COND_VAL)
        else $error("condition register not zero");
    a_summary_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        summary && !(rd_en && sel == `OSRG_SEL_EVNT) && !(wr_en && sel == `OSRG_SEL_ENAB) |=> summary)
        else $error("summary dropped on its own");

endmodule : osrg_top

// file: verilog/osrg_regs.svh
`ifndef OSRG_REGS_SVH
`define OSRG_REGS_SVH

// Register selects for the query/command port
`define OSRG_SEL_COND 2'h0
`define OSRG_SEL_ENAB 2'h1
`define OSRG_SEL_EVNT 2'h2

// Only implemented bit position (weight 256)
`define OSRG_USED_BIT 8
`define OSRG_USED_MASK 16'h0100

// Reset values
`define OSRG_ENAB_RST 16'h0000
`define OSRG_EVNT_RST 16'h0000
`define OSRG_COND_VAL 16'h0000

`endif

// file: verilog/osrg_pkg.sv
package osrg_pkg;
    typedef logic [15:0] osrg_word_t;
    typedef logic [1:0] osrg_sel_t;
endpackage : osrg_pkg

// file: bench/osrg_top_tb.sv
`include "osrg_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t mismatch", $time); end end

module osrg_top_tb
    import osrg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rstn = 0, op_cond_in = 0, wr_en = 0, rd_en = 0, summary, rd_valid;
    osrg_sel_t sel = 2'h0;
    osrg_word_t wr_data = 16'h0000, rd_data;
    int mismatches = 0, cmp_count = 0, cyc = 0, en_m = 0, ev_m = 0, prv = 0;
    osrg_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .op_cond_in(op_cond_in), .wr_en(wr_en),
        .rd_en(rd_en), .sel(sel), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .summary(summary));
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            mismatches++;
            close_out;
        end
    end
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task rd(input osrg_sel_t s, input int exp);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        sel <= s;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        if (s == `OSRG_SEL_EVNT)
            ev_m = 0;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, osrg_word_t'(exp))
        `CHK(summary, 1'((ev_m & en_m) != 0))
    endtask : rd
    task wr(input osrg_word_t d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        sel <= `OSRG_SEL_ENAB;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        en_m = d & `OSRG_USED_MASK;
    endtask : wr
    task cond(input int v);
        @(posedge clk_sys);
        op_cond_in <= v[0];
        if (v && !prv)
            ev_m = `OSRG_USED_MASK;
        prv = v;
        @(posedge clk_sys);
        #1;
        `CHK(summary, 1'((ev_m & en_m) != 0))
        `CHK(rd_valid, 1'b0)
    endtask : cond
    initial
    begin
        void'($urandom(32'h9C41));
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(`OSRG_SEL_COND, 0);
        rd(2'h3, 0);
        for (int i = 0; i < 3; i++)
        begin
            wr(osrg_word_t'($urandom));
            rd(`OSRG_SEL_ENAB, en_m);
            rd(`OSRG_SEL_ENAB, en_m);
        end
        $display("mask test done");
        wr(16'hFFFF);
        cond(1);
        rd(`OSRG_SEL_COND, 0);
        rd(`OSRG_SEL_EVNT, 256);
        rd(`OSRG_SEL_EVNT, 0);
        cond(0);
        rd(`OSRG_SEL_EVNT, 0);
        wr(16'h0000);
        cond(1);
        rd(`OSRG_SEL_COND, 0);
        rd(`OSRG_SEL_EVNT, 256);
        $display("event test done");
        wr(16'h0100);
        cond(0);
        cond(1);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        en_m = 0;
        ev_m = 256;
        #1;
        `CHK(summary, 1'b0)
        `CHK(rd_valid, 1'b0)
        `CHK(rd_data, 16'h0000)
        rd(`OSRG_SEL_ENAB, 0);
        rd(`OSRG_SEL_EVNT, 256);
        $display("reset test done");
        close_out;
    end
endmodule : osrg_top_tb
